// ### logic/pmsq_consts.svh
// Address map, field positions, reset values and timing constants of the interrupt and sequence registers
`ifndef PMSQ_CONSTS_SVH
`define PMSQ_CONSTS_SVH

// Register addresses
`define PMSQ_ADDR_IRQ_EN2      8'h2A
`define PMSQ_ADDR_IRQ_STAT2    8'h2B
`define PMSQ_ADDR_SEQ1         8'h2C
`define PMSQ_ADDR_SEQ2         8'h2D

// Bit positions of the status register; the enable register holds only the top three
`define PMSQ_BIT_SHDN          7
`define PMSQ_BIT_RISE          6
`define PMSQ_BIT_FALL          5
`define PMSQ_BIT_TEMP_HIGH     1
`define PMSQ_BIT_TEMP_MID      0

// Writable and readable masks, reset values
`define PMSQ_IRQ_EN2_MASK      8'hE0
`define PMSQ_IRQ_EN2_RESET     8'h80
`define PMSQ_IRQ_STAT2_MASK    8'hE3
`define PMSQ_IRQ_STAT2_RESET   8'h00
`define PMSQ_UNMAPPED_DATA     8'h00

// Sequence priority codes
`define PMSQ_CODE_OFF          4'h0
`define PMSQ_CODE_FIRST        4'h1
`define PMSQ_CODE_LAST         4'hC

// Time between two sequence slots
`define PMSQ_STEP_TIME_NS      1000
`define PMSQ_CLK_FREQ_MHZ      250
`define PMSQ_NS_PER_US         1000

`endif

// ### logic/pmsq_pkg.sv
// Types for the interrupt and power sequence register block
package pmsq_pkg;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pmsq_reg_req_t;

    typedef struct packed {
        logic       rdValid;
        logic [7:0] rdData;
    } pmsq_reg_rsp_t;

    typedef struct packed {
        logic forcedShutdown;
        logic highTempPrewarn;
        logic midTempPrewarn;
    } pmsq_event_t;

    // Gray coded along idle -> up -> on -> down -> idle
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_UP   = 2'b01,
        SEQ_ON   = 2'b11,
        SEQ_DOWN = 2'b10
    } pmsq_seq_state_t;

endpackage : pmsq_pkg

// ### logic/pmsq_key_edge.sv
// Rising and falling edge detector for the power key level
`timescale 1ns/1ps
module pmsq_key_edge (
    // Clock and reset
    input  logic clk,
    input  logic srst,
    // Key level and edge pulses
    input  logic keyLevel,
    output logic risePulse,
    output logic fallPulse
);

    logic prev_q;
    logic prev_d;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    always_comb begin
        prev_d = keyLevel;
        rise_d = keyLevel & ~prev_q;
        fall_d = ~keyLevel & prev_q;
    end

    // The key level is captured during reset so a key held at release gives no false edge
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= keyLevel;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign risePulse = rise_q;
    assign fallPulse = fall_q;

endmodule : pmsq_key_edge

// ### logic/pmsq_regs.sv
// Second interrupt enable/status registers and converter power sequencer
`timescale 1ns/1ps
`include "pmsq_consts.svh"
module pmsq_regs
    import pmsq_pkg::*;
#(
    parameter int unsigned STEP_TIME_NS = `PMSQ_STEP_TIME_NS,
    parameter int unsigned CLK_FREQ_MHZ = `PMSQ_CLK_FREQ_MHZ
)(
    // Clock and reset
    input  logic               clk,
    input  logic               srst,
    // Register access
    input  pmsq_reg_req_t      regReq,
    output pmsq_reg_rsp_t      regRsp,
    // Factory options for the sequence registers
    input  logic [7:0]         factorySeq1,
    input  logic [7:0]         factorySeq2,
    // Event sources
    input  logic               powerKeyInput,
    input  pmsq_event_t        events,
    // Sequencer control
    input  logic               powerUpReq,
    input  logic               powerDownReq,
    output logic [3:0]         convEnable,
    output logic               seqBusy,
    // Interrupt
    output logic               irqOut
);

    localparam int unsigned NUM_CONV      = 4;
    localparam int unsigned CODE_W        = 4;
    // Step times below one clock round up to a single cycle
    localparam int unsigned STEP_RAW      = (STEP_TIME_NS * CLK_FREQ_MHZ) / `PMSQ_NS_PER_US;
    localparam int unsigned STEP_CYCLES   = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam int unsigned STEP_W        = $clog2(STEP_CYCLES + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

    // Power key edges; a status bit follows one clock after the edge pulse
    logic keyRise;
    logic keyFall;

    pmsq_key_edge u_key_edge (
        .clk       (clk),
        .srst      (srst),
        .keyLevel  (powerKeyInput),
        .risePulse (keyRise),
        .fallPulse (keyFall)
    );

    // Register group: enable, status, sequence codes
    logic [7:0] irqEn_q;
    logic [7:0] irqEn_d;
    logic [7:0] irqStat_q;
    logic [7:0] irqStat_d;
    logic [7:0] seq1_q;
    logic [7:0] seq1_d;
    logic [7:0] seq2_q;
    logic [7:0] seq2_d;
    logic [7:0] eventVec;
    logic       wrEn2;
    logic       rdStat2;
    logic       wrSeq1;
    logic       wrSeq2;

    logic       selEn2;
    logic       selStat2;
    logic       selSeq1;
    logic       selSeq2;

    // Reserved status bits have no source, so they always read zero
    always_comb begin
        eventVec                     = 8'h00;
        eventVec[`PMSQ_BIT_SHDN]      = events.forcedShutdown;
        eventVec[`PMSQ_BIT_RISE]      = keyRise;
        eventVec[`PMSQ_BIT_FALL]      = keyFall;
        eventVec[`PMSQ_BIT_TEMP_HIGH] = events.highTempPrewarn;
        eventVec[`PMSQ_BIT_TEMP_MID]  = events.midTempPrewarn;
    end

    // One select per mapped register, shared by the write and clear paths; the read mux decodes the address itself
    assign selEn2   = (regReq.addr == `PMSQ_ADDR_IRQ_EN2);
    assign selStat2 = (regReq.addr == `PMSQ_ADDR_IRQ_STAT2);
    assign selSeq1  = (regReq.addr == `PMSQ_ADDR_SEQ1);
    assign selSeq2  = (regReq.addr == `PMSQ_ADDR_SEQ2);

    assign wrEn2    = regReq.wrEn && selEn2;
    assign wrSeq1   = regReq.wrEn && selSeq1;
    assign wrSeq2   = regReq.wrEn && selSeq2;
    assign rdStat2  = regReq.rdEn && selStat2;

    always_comb begin
        irqEn_d   = irqEn_q;
        irqStat_d = irqStat_q;
        seq1_d    = seq1_q;
        seq2_d    = seq2_q;
        // Only the three enable bits store; the low five stay zero
        if (wrEn2) begin
            irqEn_d = regReq.wrData & `PMSQ_IRQ_EN2_MASK;
        end
        if (wrSeq1) begin
            seq1_d = regReq.wrData;
        end
        if (wrSeq2) begin
            seq2_d = regReq.wrData;
        end
        // Status is software read-only; a read clears it, but an event in the same cycle survives
        if (rdStat2) begin
            irqStat_d = 8'h00;
        end
        irqStat_d = (irqStat_d | eventVec) & `PMSQ_IRQ_STAT2_MASK;
    end

    // Sequence codes reload from the factory option at every reset
    always_ff @(posedge clk) begin
        if (srst) begin
            irqEn_q   <= `PMSQ_IRQ_EN2_RESET;
            irqStat_q <= `PMSQ_IRQ_STAT2_RESET;
            seq1_q    <= factorySeq1;
            seq2_q    <= factorySeq2;
        end else begin
            irqEn_q   <= irqEn_d;
            irqStat_q <= irqStat_d;
            seq1_q    <= seq1_d;
            seq2_q    <= seq2_d;
        end
    end

    // Read response and interrupt output; a read and a write in one cycle return the old contents
    localparam logic [7:0] EN_MASK = `PMSQ_IRQ_EN2_MASK;

    logic [7:0] irqHit;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic       rdValid_q;
    logic       rdValid_d;
    logic       irq_q;
    logic       irq_d;

    // A status bit raises the interrupt only while its enable is set
    genvar bi;
    generate
        for (bi = 0; bi < 8; bi++) begin : g_irq_hit
            assign irqHit[bi] = irqStat_q[bi] & irqEn_q[bi] & EN_MASK[bi];
        end
    endgenerate

    always_comb begin
        rdValid_d = regReq.rdEn;
        rdData_d  = rdData_q;
        if (regReq.rdEn) begin
            case (regReq.addr)
                `PMSQ_ADDR_IRQ_EN2:   rdData_d = irqEn_q & `PMSQ_IRQ_EN2_MASK;
                `PMSQ_ADDR_IRQ_STAT2: rdData_d = irqStat_q;
                `PMSQ_ADDR_SEQ1:      rdData_d = seq1_q;
                `PMSQ_ADDR_SEQ2:      rdData_d = seq2_q;
                default:              rdData_d = `PMSQ_UNMAPPED_DATA;
            endcase
        end
        // Temperature bits have no enable here, so they never raise this output
        irq_d = |irqHit;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
            irq_q     <= irq_d;
        end
    end

    assign regRsp.rdData  = rdData_q;
    assign regRsp.rdValid = rdValid_q;
    assign irqOut         = irq_q;

    // Power sequencer; codes are read live, so a code rewritten mid-ramp acts at its new slot
    logic [NUM_CONV-1:0][CODE_W-1:0] convCode;
    logic [NUM_CONV-1:0]             slotHit;
    logic [NUM_CONV-1:0]             codeLive;

    // Converter 3 code sits in the low nibble of the second sequence register
    assign convCode = {seq2_q, seq1_q};

    pmsq_seq_state_t     state_q;
    pmsq_seq_state_t     state_d;
    logic [CODE_W-1:0]   slot_q;
    logic [CODE_W-1:0]   slot_d;
    logic [STEP_W-1:0]   stepCnt_q;
    logic [STEP_W-1:0]   stepCnt_d;
    logic [NUM_CONV-1:0] convEn_q;
    logic [NUM_CONV-1:0] convEn_d;
    logic                stepDone;
    logic                downReq;

    // Codes above the last slot are never reached, so such a converter stays off
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONV; gi++) begin : g_slot
            assign codeLive[gi] = (convCode[gi] != `PMSQ_CODE_OFF) && (convCode[gi] <= `PMSQ_CODE_LAST);
            assign slotHit[gi]  = codeLive[gi] && (convCode[gi] == slot_q);
        end
    endgenerate

    assign stepDone = (stepCnt_q == STEP_LAST);
    // A forced shutdown also walks the converters down in reverse order
    assign downReq  = powerDownReq | events.forcedShutdown;

    // A slot's converters switch at its last clock, so each slot spans STEP_CYCLES clocks
    always_comb begin
        state_d   = state_q;
        slot_d    = slot_q;
        stepCnt_d = stepCnt_q;
        convEn_d  = convEn_q;
        case (state_q)
            SEQ_IDLE: begin
                stepCnt_d = '0;
                if (powerUpReq && !downReq) begin
                    state_d = SEQ_UP;
                    slot_d  = `PMSQ_CODE_FIRST;
                end
            end
            SEQ_UP: begin
                if (downReq) begin
                    // Abort mid ramp: unwind from the current slot
                    state_d   = SEQ_DOWN;
                    stepCnt_d = '0;
                end else if (stepDone) begin
                    convEn_d  = convEn_q | slotHit;
                    stepCnt_d = '0;
                    if (slot_q == `PMSQ_CODE_LAST) begin
                        state_d = SEQ_ON;
                    end else begin
                        slot_d = slot_q + 1'b1;
                    end
                end else begin
                    stepCnt_d = stepCnt_q + 1'b1;
                end
            end
            SEQ_ON: begin
                stepCnt_d = '0;
                if (downReq) begin
                    state_d = SEQ_DOWN;
                    slot_d  = `PMSQ_CODE_LAST;
                end
            end
            SEQ_DOWN: begin
                if (stepDone) begin
                    convEn_d  = convEn_q & ~slotHit;
                    stepCnt_d = '0;
                    if (slot_q == `PMSQ_CODE_FIRST) begin
                        state_d = SEQ_IDLE;
                        slot_d  = `PMSQ_CODE_OFF;
                    end else begin
                        slot_d = slot_q - 1'b1;
                    end
                end else begin
                    stepCnt_d = stepCnt_q + 1'b1;
                end
            end
            default: begin
                // An illegal state drops every converter at once rather than guess an order
                state_d   = SEQ_IDLE;
                slot_d    = `PMSQ_CODE_OFF;
                stepCnt_d = '0;
                convEn_d  = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q   <= SEQ_IDLE;
            slot_q    <= `PMSQ_CODE_OFF;
            stepCnt_q <= '0;
            convEn_q  <= '0;
        end else begin
            state_q   <= state_d;
            slot_q    <= slot_d;
            stepCnt_q <= stepCnt_d;
            convEn_q  <= convEn_d;
        end
    end

    assign convEnable = convEn_q;
    // Decoded from the state register, so busy carries no extra latency
    assign seqBusy    = (state_q == SEQ_UP) || (state_q == SEQ_DOWN);

endmodule : pmsq_regs

// ### sim/pmsq_regs_asserts.sv
// Concurrent checks on the ports of the interrupt and sequence register block
`timescale 1ns/1ps
module pmsq_regs_asserts
    import pmsq_pkg::*;
#(
    parameter int unsigned STEP_TIME_NS = 1000,
    parameter int unsigned CLK_FREQ_MHZ = 250
)(
    // Clock and reset
    input logic          clk,
    input logic          srst,
    // Register port
    input pmsq_reg_req_t regReq,
    input pmsq_reg_rsp_t regRsp,
    // Events and sequencer
    input logic          powerKeyInput,
    input pmsq_event_t   events,
    input logic          powerUpReq,
    input logic          powerDownReq,
    input logic [3:0]    convEnable,
    input logic          seqBusy,
    input logic          irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic rdStat;
    assign rdStat = regReq.rdEn && regReq.addr == 8'h2B;

    // Reference model: when a key edge becomes readable, and whether the sequencer sits idle
    logic keyPrev;
    logic riseD1;
    logic riseD2;
    logic risePend;
    logic fallD1;
    logic fallD2;
    logic fallPend;
    logic inIdle;
    logic goingDown;
    logic downReq;
    assign downReq = powerDownReq || events.forcedShutdown;

    always_ff @(posedge clk) begin
        keyPrev <= powerKeyInput;
        if (srst) begin
            riseD1    <= 1'b0;
            riseD2    <= 1'b0;
            risePend  <= 1'b0;
            fallD1    <= 1'b0;
            fallD2    <= 1'b0;
            fallPend  <= 1'b0;
            inIdle    <= 1'b1;
            goingDown <= 1'b0;
        end else begin
            riseD1   <= powerKeyInput & ~keyPrev;
            riseD2   <= riseD1;
            risePend <= riseD2 | (risePend & ~rdStat);
            fallD1   <= ~powerKeyInput & keyPrev;
            fallD2   <= fallD1;
            fallPend <= fallD2 | (fallPend & ~rdStat);
            if (inIdle) begin
                inIdle <= !(powerUpReq && !downReq);
            end else if (goingDown && !seqBusy) begin
                goingDown <= 1'b0;
                inIdle    <= !(powerUpReq && !downReq);
            end else if (downReq) begin
                goingDown <= 1'b1;
            end
        end
    end

    chk_en_reset: assert property (
        $fell(srst) ##1 (regReq.rdEn && regReq.addr == 8'h2A) |=> regRsp.rdData[7:5] == 3'b100)
        else $error("enable reset value wrong");
    chk_en_reserved: assert property (
        regReq.rdEn && regReq.addr == 8'h2A |=> regRsp.rdValid && regRsp.rdData[4:0] == 5'h00)
        else $error("reserved enable bits not zero");
    chk_temp_flags: assert property (
        events.highTempPrewarn && events.midTempPrewarn ##1 rdStat |=> regRsp.rdData[1:0] == 2'b11)
        else $error("temperature flags missing");
    chk_rise_flag: assert property (
        rdStat && risePend |=> regRsp.rdData[6])
        else $error("key rise flag missing");
    chk_fall_flag: assert property (
        rdStat && fallPend |=> regRsp.rdData[5])
        else $error("key fall flag missing");
    chk_irq_masked: assert property (
        (regReq.wrEn && regReq.addr == 8'h2A && regReq.wrData[7:5] == 3'b000)
        ##1 !(regReq.wrEn && regReq.addr == 8'h2A) |=> !irqOut)
        else $error("interrupt with all enables off");
    chk_up_start: assert property (
        inIdle && powerUpReq && !powerDownReq && !events.forcedShutdown && !seqBusy |=> seqBusy)
        else $error("power-up not started");
    chk_down_order: assert property (
        powerDownReq && !seqBusy && convEnable != 4'h0 |=> ((convEnable & ~$past(convEnable)) == 4'h0) [*8])
        else $error("converter switched on during power-down");
endmodule : pmsq_regs_asserts

bind pmsq_regs pmsq_regs_asserts #(.STEP_TIME_NS(STEP_TIME_NS), .CLK_FREQ_MHZ(CLK_FREQ_MHZ)) u_chk (
    .clk(clk), .srst(srst), .regReq(regReq), .regRsp(regRsp), .powerKeyInput(powerKeyInput),
    .events(events), .powerUpReq(powerUpReq), .powerDownReq(powerDownReq),
    .convEnable(convEnable), .seqBusy(seqBusy), .irqOut(irqOut));

// ### sim/pmsq_host.sv
// Host model issuing one-cycle register strobes on the parallel register port
`timescale 1ns/1ps
module pmsq_host
    import pmsq_pkg::*;
(
    // Clock
    input  logic          clk,
    // Register port
    output pmsq_reg_req_t regReq
);
    initial regReq = '0;

    // Released address and data go to their inverse so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 regReq = '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
        @(posedge clk);
        #1 regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
    endtask : access
endmodule : pmsq_host

// ### sim/tb.sv
// Self-checking bench for the interrupt and sequence register block
`timescale 1ns/1ps
module tb;
    import pmsq_pkg::*;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic [7:0]    f1, f2, d;
    logic          key = 1'b0;
    pmsq_event_t   ev = '0;
    logic          upReq = 1'b0;
    logic          dnReq = 1'b0;
    pmsq_reg_req_t regReq;
    pmsq_reg_rsp_t regRsp;
    logic [3:0]    convEnable;
    logic [3:0]    convPrev = 4'h0;
    logic          seqBusy, irqOut;
    logic [7:0]    rdQ[$];
    logic [3:0]    cvQ[$];
    int            error_cnt = 0;
    int            n_tests = 0;

    always #2 clk = ~clk;

    pmsq_host host (.clk(clk), .regReq(regReq));

    // One-cycle sequence slots keep the run short
    pmsq_regs #(.STEP_TIME_NS(4), .CLK_FREQ_MHZ(250)) dut (
        .clk(clk), .srst(srst), .regReq(regReq), .regRsp(regRsp), .factorySeq1(f1), .factorySeq2(f2),
        .powerKeyInput(key), .events(ev), .powerUpReq(upReq), .powerDownReq(dnReq),
        .convEnable(convEnable), .seqBusy(seqBusy), .irqOut(irqOut));

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic compare(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : compare

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdQ.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd

    task automatic waitIdle();
        int i;
        repeat (2) @(posedge clk);
        #1;
        for (i = 0; i < 100 && seqBusy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        // Let the monitor see the last converter change
        @(posedge clk);
        #1;
        if (i == 100) begin
            compare("seqBusy", 8'h00, 8'h01);
            end_of_test();
        end
    endtask : waitIdle

    // Results are matched in arrival order against the oldest note
    always @(negedge clk) begin
        if (!srst && regRsp.rdValid === 1'b1)
            compare("rdData", rdQ.pop_front(), regRsp.rdData);
        if (!srst && convEnable !== convPrev)
            compare("convEnable", {4'h0, cvQ.pop_front()}, {4'h0, convEnable});
        convPrev <= convEnable;
    end

    initial begin
        void'($urandom(18));
        f1 = $urandom;
        f2 = $urandom;
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        rd(8'h2A, 8'h80);
        rd(8'h2B, 8'h00);
        rd(8'h2C, f1);
        rd(8'h2D, f2);
        rd(8'h3C, 8'h00);
        host.access(1'b1, 8'h2A, 8'hFF);
        rd(8'h2A, 8'hE0);
        host.access(1'b1, 8'h2B, 8'hFF);
        rd(8'h2B, 8'h00);
        d = $urandom;
        host.access(1'b1, 8'h2C, d);
        rd(8'h2C, d);
        d = $urandom;
        host.access(1'b1, 8'h2D, d);
        rd(8'h2D, d);
        // Only the rising-edge interrupt enabled
        host.access(1'b1, 8'h2A, 8'h40);
        key = 1'b1;
        repeat (6) @(posedge clk);
        #1 compare("irqOut", 8'h01, {7'h00, irqOut});
        rd(8'h2B, 8'h40);
        repeat (2) @(posedge clk);
        #1 compare("irqOut", 8'h00, {7'h00, irqOut});
        key = 1'b0;
        repeat (6) @(posedge clk);
        #1 compare("irqOut", 8'h00, {7'h00, irqOut});
        rd(8'h2B, 8'h20);
        host.access(1'b1, 8'h2A, 8'h00);
        ev = '{1'b1, 1'b1, 1'b1};
        fork
            rd(8'h2B, 8'h83);
            begin
                @(posedge clk);
                #1 ev = '0;
            end
        join
        compare("irqOut", 8'h00, {7'h00, irqOut});
        // Conv1 first, conv4 at slot 5, conv2 last, conv3 off
        host.access(1'b1, 8'h2C, 8'hC1);
        host.access(1'b1, 8'h2D, 8'h50);
        cvQ = '{4'h1, 4'h9, 4'hB, 4'h9, 4'h1, 4'h0};
        upReq = 1'b1;
        @(posedge clk);
        #1 upReq = 1'b0;
        waitIdle();
        dnReq = 1'b1;
        @(posedge clk);
        #1 dnReq = 1'b0;
        waitIdle();
        compare("pending conv", 8'h00, 8'(cvQ.size()));
        // Forced shutdown with its interrupt enabled: flag, interrupt and a reverse ramp
        host.access(1'b1, 8'h2A, 8'h80);
        cvQ = '{4'h1, 4'h9, 4'hB, 4'h9, 4'h1, 4'h0};
        upReq = 1'b1;
        @(posedge clk);
        #1 upReq = 1'b0;
        waitIdle();
        ev.forcedShutdown = 1'b1;
        @(posedge clk);
        #1 ev.forcedShutdown = 1'b0;
        repeat (2) @(posedge clk);
        #1 compare("irqOut", 8'h01, {7'h00, irqOut});
        rd(8'h2B, 8'h80);
        waitIdle();
        compare("irqOut", 8'h00, {7'h00, irqOut});
        compare("pending conv", 8'h00, 8'(cvQ.size()));
        end_of_test();
    end
endmodule : tb
